/* rtl/host_fifo_port_pkg.sv */
// Summary of operation
// - Host bus moves 16 bits per access; internal words are 32 bits.
// - Two 16-bit host accesses, low then high half, form one word.
// - Writes to read-only registers are ignored and change nothing.
// - Reads of write-only locations always return zero.
// - Writing one clears a write_one_clear bit; writing zero leaves it.
// - A clear_on_read bit returns to zero when the host reads it.
// - Latched low or high conditions hold until their register is read.
// - Fields kept_over_soft_reset keep their value through software reset.
// - Hardware reset loads every internal register with its default value.
// - Four FIFOs; data and receive status FIFO sizes set by register.
// - Receive status and receive data ports ignore host writes.
// - Reading receive status pop port returns and removes the head.
// - Reading receive status peek port returns head without removing it.
// - Sixteen aliased words read and always remove receive data head.
// - Reading transmit status pop port returns and removes the head.
// - Reading transmit status peek port returns head and keeps it.
// - Transmit data is write only; sixteen aliased words push one FIFO.
package host_fifo_port_pkg;

    localparam int DEPTH = 16;
    localparam int PTR_W = 4;
    localparam int CNT_W = 5;

    localparam logic [1:0] FIFO_RXS = 2'h0;
    localparam logic [1:0] FIFO_RXD = 2'h1;
    localparam logic [1:0] FIFO_TXS = 2'h2;
    localparam logic [1:0] FIFO_TXD = 2'h3;

    // Byte addresses; bits 7:6 select the aliased data windows
    localparam logic [1:0] WIN_RXD = 2'h0;
    localparam logic [1:0] WIN_TXD = 2'h1;
    localparam logic [7:0] ADDR_RXS_POP = 8'h80;
    localparam logic [7:0] ADDR_RXS_PEEK = 8'h84;
    localparam logic [7:0] ADDR_TXS_POP = 8'h88;
    localparam logic [7:0] ADDR_TXS_PEEK = 8'h8C;
    localparam logic [7:0] ADDR_CFG = 8'h90;
    localparam logic [7:0] ADDR_LEVEL = 8'h94;
    localparam logic [7:0] ADDR_EVT = 8'h98;
    localparam logic [7:0] ADDR_LATCH = 8'h9C;
    localparam logic [7:0] ADDR_CMD = 8'hA0;
    localparam logic [7:0] ADDR_KEEP = 8'hA4;

    // Size limits in entries, one byte each
    localparam int CFG_RXS_LIM_LSB = 0;
    localparam int CFG_RXD_LIM_LSB = 8;
    localparam int CFG_TXD_LIM_LSB = 16;
    localparam int CFG_SRST_BIT = 31;
    localparam logic [31:0] CFG_RESET = 32'h00101010;
    localparam logic [31:0] CFG_WMASK = 32'h001F1F1F;

    localparam int LVL_RXS_LSB = 0;
    localparam int LVL_RXD_LSB = 8;
    localparam int LVL_TXS_LSB = 16;
    localparam int LVL_TXD_LSB = 24;

    localparam int EVT_RXS_OVF = 0;
    localparam int EVT_RXD_OVF = 1;
    localparam int EVT_TXS_OVF = 2;
    localparam int EVT_TXD_OVF = 3;
    localparam int EVT_UNDERRUN = 4;

    localparam int LATCH_LINK_LOW = 0;
    localparam int LATCH_ERR_HIGH = 1;
    localparam int LATCH_TXS_READ = 8;
    localparam logic [31:0] LATCH_RESET = 32'h00000001;

    localparam int CMD_RX_FLUSH = 0;
    localparam int CMD_TX_FLUSH = 1;

    localparam logic [31:0] KEEP_MASK = 32'h0000FFFF;

    typedef struct packed {
        logic [DEPTH-1:0][31:0] mem;
        logic [PTR_W-1:0] rd;
        logic [PTR_W-1:0] wr;
        logic [CNT_W-1:0] cnt;
    } fifo_t;

    typedef struct packed {
        fifo_t [3:0] fifo;
        logic [2:0] rdy;
        logic [31:0] tx_head;
        logic tx_valid;
        logic [31:0] cfg;
        logic [31:0] evt;
        logic [31:0] latch;
        logic [31:0] keep;
        logic srst;
        logic [31:0] rd_hold;
        logic rd_lo;
        logic [5:0] rd_dw;
        logic [15:0] wr_lo;
        logic wr_lo_ok;
        logic [5:0] wr_dw;
        logic [15:0] rdata;
        logic rvalid;
    } state_t;

    localparam state_t STATE_RESET = '{
        cfg: CFG_RESET,
        latch: LATCH_RESET,
        rdy: 3'h7,
        default: '0
    };

endpackage : host_fifo_port_pkg

/* rtl/host_fifo_port_access.sv */
`timescale 1ns/10ps
module host_fifo_port_access (
    input wire logic mclk_in,
    input wire logic reset_in,
    input wire logic [7:0] host_addr_in,
    input wire logic host_rd_in,
    input wire logic host_wr_in,
    input wire logic [15:0] host_wdata_in,
    output logic [15:0] host_rdata_out,
    output logic host_rvalid_out,
    input wire logic [31:0] rx_sts_in,
    input wire logic rx_sts_push_in,
    output logic rx_sts_ready_out,
    input wire logic [31:0] rx_data_in,
    input wire logic rx_data_push_in,
    output logic rx_data_ready_out,
    input wire logic [31:0] tx_sts_in,
    input wire logic tx_sts_push_in,
    output logic tx_sts_ready_out,
    output logic [31:0] tx_data_out,
    output logic tx_data_valid_out,
    input wire logic tx_data_pop_in,
    input wire logic link_in,
    input wire logic rx_err_in
);

    host_fifo_port_pkg::state_t q;
    host_fifo_port_pkg::state_t n;

    function automatic host_fifo_port_pkg::fifo_t fifo_step(
        input host_fifo_port_pkg::fifo_t f,
        input logic push,
        input logic pop,
        input logic [31:0] din,
        input logic flush
    );
        host_fifo_port_pkg::fifo_t r;
        r = f;
        if (flush) begin
            r.rd = '0;
            r.wr = '0;
            r.cnt = '0;
        end else begin
            if (push) begin
                r.mem[f.wr] = din;
                r.wr = f.wr + 4'h1;
            end
            if (pop) begin
                r.rd = f.rd + 4'h1;
            end
            if (push && !pop) begin
                r.cnt = f.cnt + 5'h01;
            end else if (pop && !push) begin
                r.cnt = f.cnt - 5'h01;
            end
        end
        return r;
    endfunction : fifo_step

    // Configured size, never above the physical depth
    function automatic logic [4:0] size_limit(input logic [7:0] field);
        logic [4:0] r;
        r = 5'(host_fifo_port_pkg::DEPTH);
        if (field < 8'(host_fifo_port_pkg::DEPTH)) begin
            r = field[4:0];
        end
        return r;
    endfunction : size_limit

    function automatic logic [31:0] head(
        input host_fifo_port_pkg::fifo_t f
    );
        return (f.cnt != 5'h00) ? f.mem[f.rd] : 32'h00000000;
    endfunction : head

    always_comb begin
        logic [5:0] dw;
        logic half;
        logic [31:0] word;
        logic [31:0] rword;
        logic [31:0] val;
        logic [3:0] push;
        logic [3:0] pop;
        logic [3:0] flush;
        logic [3:0][31:0] pdata;
        logic [2:0][4:0] lim;
        n = q;
        dw = host_addr_in[7:2];
        half = host_addr_in[1];
        word = 32'h00000000;
        rword = 32'h00000000;
        val = 32'h00000000;
        push = 4'h0;
        pop = 4'h0;
        flush = 4'h0;
        pdata = '0;
        n.rvalid = 1'b0;
        n.srst = 1'b0;
        lim[0] = size_limit(q.cfg[host_fifo_port_pkg::CFG_RXS_LIM_LSB +: 8]);
        lim[1] = size_limit(q.cfg[host_fifo_port_pkg::CFG_RXD_LIM_LSB +: 8]);
        lim[2] = size_limit(q.cfg[host_fifo_port_pkg::CFG_TXD_LIM_LSB +: 8]);

        // Read decode
        if (host_addr_in[7:6] == host_fifo_port_pkg::WIN_RXD) begin
            word = head(q.fifo[host_fifo_port_pkg::FIFO_RXD]);
        end else if (host_addr_in[7:6] == host_fifo_port_pkg::WIN_TXD) begin
            word = 32'h00000000;
        end else begin
            unique case ({host_addr_in[7:2], 2'b00})
                host_fifo_port_pkg::ADDR_RXS_POP,
                host_fifo_port_pkg::ADDR_RXS_PEEK:
                    word = head(q.fifo[host_fifo_port_pkg::FIFO_RXS]);
                host_fifo_port_pkg::ADDR_TXS_POP,
                host_fifo_port_pkg::ADDR_TXS_PEEK:
                    word = head(q.fifo[host_fifo_port_pkg::FIFO_TXS]);
                host_fifo_port_pkg::ADDR_CFG: word = q.cfg;
                host_fifo_port_pkg::ADDR_LEVEL: begin
                    word[host_fifo_port_pkg::LVL_RXS_LSB +: 5] =
                        q.fifo[host_fifo_port_pkg::FIFO_RXS].cnt;
                    word[host_fifo_port_pkg::LVL_RXD_LSB +: 5] =
                        q.fifo[host_fifo_port_pkg::FIFO_RXD].cnt;
                    word[host_fifo_port_pkg::LVL_TXS_LSB +: 5] =
                        q.fifo[host_fifo_port_pkg::FIFO_TXS].cnt;
                    word[host_fifo_port_pkg::LVL_TXD_LSB +: 5] =
                        q.fifo[host_fifo_port_pkg::FIFO_TXD].cnt;
                end
                host_fifo_port_pkg::ADDR_EVT: word = q.evt;
                host_fifo_port_pkg::ADDR_LATCH: word = q.latch;
                host_fifo_port_pkg::ADDR_CMD: word = 32'h00000000;
                host_fifo_port_pkg::ADDR_KEEP: word = q.keep;
                default: word = 32'h00000000;
            endcase
        end

        if (host_rd_in) begin
            n.rvalid = 1'b1;
            if (!half) begin
                // Low half captures the whole word for the pair
                n.rd_hold = word;
                n.rd_lo = 1'b1;
                n.rd_dw = dw;
                n.rdata = word[15:0];
            end else begin
                rword = (q.rd_lo && q.rd_dw == dw) ? q.rd_hold : word;
                n.rdata = rword[31:16];
                n.rd_lo = 1'b0;
                // Side effects only on the completing half
                if (host_addr_in[7:6] == host_fifo_port_pkg::WIN_RXD) begin
                    pop[host_fifo_port_pkg::FIFO_RXD] = 1'b1;
                end
                unique case ({dw, 2'b00})
                    host_fifo_port_pkg::ADDR_RXS_POP:
                        pop[host_fifo_port_pkg::FIFO_RXS] = 1'b1;
                    host_fifo_port_pkg::ADDR_TXS_POP:
                        pop[host_fifo_port_pkg::FIFO_TXS] = 1'b1;
                    host_fifo_port_pkg::ADDR_LATCH: begin
                        n.latch = 32'h00000000;
                        n.latch[host_fifo_port_pkg::LATCH_LINK_LOW] = 1'b1;
                    end
                    default: begin
                        // Peek ports leave the head in place
                    end
                endcase
            end
        end

        // Underrun: a host pop of an empty FIFO is dropped and flagged
        for (int i = 0; i < 4; i++) begin
            if (pop[i] && q.fifo[i].cnt == 5'h00) begin
                pop[i] = 1'b0;
                n.evt[host_fifo_port_pkg::EVT_UNDERRUN] = 1'b1;
            end
        end

        if (host_wr_in) begin
            if (!half) begin
                n.wr_lo = host_wdata_in;
                n.wr_lo_ok = 1'b1;
                n.wr_dw = dw;
            end else begin
                val = {host_wdata_in,
                    (q.wr_lo_ok && q.wr_dw == dw) ? q.wr_lo : 16'h0000};
                n.wr_lo_ok = 1'b0;
                // Receive windows, status ports and level are read only;
                if (host_addr_in[7:6] == host_fifo_port_pkg::WIN_TXD) begin
                    if (q.fifo[host_fifo_port_pkg::FIFO_TXD].cnt < lim[2])
                    begin
                        push[host_fifo_port_pkg::FIFO_TXD] = 1'b1;
                        pdata[host_fifo_port_pkg::FIFO_TXD] = val;
                    end else begin
                        n.evt[host_fifo_port_pkg::EVT_TXD_OVF] = 1'b1;
                    end
                end else if (host_addr_in[7:6] != host_fifo_port_pkg::WIN_RXD)
                begin
                    unique case ({dw, 2'b00})
                        host_fifo_port_pkg::ADDR_CFG: begin
                            n.cfg = val & host_fifo_port_pkg::CFG_WMASK;
                            n.srst = val[host_fifo_port_pkg::CFG_SRST_BIT];
                        end
                        host_fifo_port_pkg::ADDR_EVT:
                            n.evt = q.evt & ~val;
                        host_fifo_port_pkg::ADDR_CMD: begin
                            flush[host_fifo_port_pkg::FIFO_RXS] =
                                val[host_fifo_port_pkg::CMD_RX_FLUSH];
                            flush[host_fifo_port_pkg::FIFO_RXD] =
                                val[host_fifo_port_pkg::CMD_RX_FLUSH];
                            flush[host_fifo_port_pkg::FIFO_TXS] =
                                val[host_fifo_port_pkg::CMD_TX_FLUSH];
                            flush[host_fifo_port_pkg::FIFO_TXD] =
                                val[host_fifo_port_pkg::CMD_TX_FLUSH];
                        end
                        host_fifo_port_pkg::ADDR_KEEP: n.keep = val;
                        default: begin
                        end
                    endcase
                end
            end
        end

        // Device-side traffic; a push while not ready is dropped and flagged
        if (rx_sts_push_in) begin
            if (q.rdy[0]) begin
                push[host_fifo_port_pkg::FIFO_RXS] = 1'b1;
                pdata[host_fifo_port_pkg::FIFO_RXS] = rx_sts_in;
            end else begin
                n.evt[host_fifo_port_pkg::EVT_RXS_OVF] = 1'b1;
            end
        end
        if (rx_data_push_in) begin
            if (q.rdy[1]) begin
                push[host_fifo_port_pkg::FIFO_RXD] = 1'b1;
                pdata[host_fifo_port_pkg::FIFO_RXD] = rx_data_in;
            end else begin
                n.evt[host_fifo_port_pkg::EVT_RXD_OVF] = 1'b1;
            end
        end
        if (tx_sts_push_in) begin
            n.latch[host_fifo_port_pkg::LATCH_TXS_READ] = 1'b1;
            if (q.rdy[2]) begin
                push[host_fifo_port_pkg::FIFO_TXS] = 1'b1;
                pdata[host_fifo_port_pkg::FIFO_TXS] = tx_sts_in;
            end else begin
                n.evt[host_fifo_port_pkg::EVT_TXS_OVF] = 1'b1;
            end
        end
        pop[host_fifo_port_pkg::FIFO_TXD] = tx_data_pop_in && q.tx_valid;

        // Live conditions applied after the read clear, so the live condition wins
        if (!link_in) begin
            n.latch[host_fifo_port_pkg::LATCH_LINK_LOW] = 1'b0;
        end
        if (rx_err_in) begin
            n.latch[host_fifo_port_pkg::LATCH_ERR_HIGH] = 1'b1;
        end

        for (int i = 0; i < 4; i++) begin
            n.fifo[i] = fifo_step(q.fifo[i], push[i] & ~flush[i],
                pop[i] & ~flush[i], pdata[i], flush[i]);
        end

        n.rdy[0] = n.fifo[host_fifo_port_pkg::FIFO_RXS].cnt < lim[0];
        n.rdy[1] = n.fifo[host_fifo_port_pkg::FIFO_RXD].cnt < lim[1];
        n.rdy[2] = n.fifo[host_fifo_port_pkg::FIFO_TXS].cnt <
            5'(host_fifo_port_pkg::DEPTH);
        n.tx_head = head(n.fifo[host_fifo_port_pkg::FIFO_TXD]);
        n.tx_valid = n.fifo[host_fifo_port_pkg::FIFO_TXD].cnt != 5'h00;

        // Software reset loads defaults but keeps protected bits
        if (q.srst) begin
            n = host_fifo_port_pkg::STATE_RESET;
            n.keep = q.keep & host_fifo_port_pkg::KEEP_MASK;
        end
    end

    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            q <= host_fifo_port_pkg::STATE_RESET;
        end else begin
            q <= n;
        end
    end

    assign host_rdata_out = q.rdata;
    assign host_rvalid_out = q.rvalid;
    assign rx_sts_ready_out = q.rdy[0];
    assign rx_data_ready_out = q.rdy[1];
    assign tx_sts_ready_out = q.rdy[2];
    assign tx_data_out = q.tx_head;
    assign tx_data_valid_out = q.tx_valid;

endmodule : host_fifo_port_access

/* testbench/host_fifo_port_sva.sv */
`timescale 1ns/10ps
module host_fifo_port_sva (
    input wire logic mclk_in,
    input wire logic reset_in,
    input wire logic [7:0] host_addr_in,
    input wire logic host_rd_in,
    input wire logic host_wr_in,
    input wire logic [15:0] host_rdata_out,
    input wire logic host_rvalid_out,
    input wire logic rx_sts_push_in,
    input wire logic rx_sts_ready_out,
    input wire logic [31:0] tx_data_out,
    input wire logic tx_data_valid_out,
    input wire logic tx_data_pop_in
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (reset_in);
    property p_rvalid_pulse; host_rd_in |=> host_rvalid_out; endproperty
    a_rvalid_pulse: assert property (p_rvalid_pulse)
        else $error("rvalid missing after read");
    property p_rvalid_only; !host_rd_in |=> !host_rvalid_out; endproperty
    a_rvalid_only: assert property (p_rvalid_only)
        else $error("rvalid without read");
    property p_rdata_hold;
        $changed(host_rdata_out) && host_rdata_out != 16'h0000
            |-> host_rvalid_out;
    endproperty
    a_rdata_hold: assert property (p_rdata_hold)
        else $error("read data changed without rvalid");
    property p_wo_zero;
        host_rd_in && (host_addr_in[7:6] == 2'h1 || host_addr_in[7:2] == 6'h28)
            |=> host_rdata_out == 16'h0000;
    endproperty
    a_wo_zero: assert property (p_wo_zero)
        else $error("write only location read nonzero");
    property p_push_high;
        $rose(tx_data_valid_out) |-> $past(host_wr_in) &&
            $past(host_addr_in[7:6]) == 2'h1 && $past(host_addr_in[1]);
    endproperty
    a_push_high: assert property (p_push_high)
        else $error("tx data appeared without high half write");
    property p_tx_empty;
        !tx_data_valid_out |-> tx_data_out == 32'h0;
    endproperty
    a_tx_empty: assert property (p_tx_empty)
        else $error("tx data nonzero while empty");
    property p_txd_fall;
        $fell(tx_data_valid_out) |-> $past(tx_data_pop_in) ||
            $past(host_wr_in) || $past(host_wr_in, 2) || $past(host_wr_in, 3);
    endproperty
    a_txd_fall: assert property (p_txd_fall)
        else $error("tx data lost without pop");
    property p_rxs_full;
        $fell(rx_sts_ready_out) |-> $past(rx_sts_push_in) ||
            $past(host_wr_in, 2) || $past(host_wr_in, 3);
    endproperty
    a_rxs_full: assert property (p_rxs_full)
        else $error("rx status ready fell without push");
    c_rx_pop: cover property (host_rd_in && host_addr_in == 8'h82);
    c_tx_rise: cover property ($rose(tx_data_valid_out));
    c_rxs_full: cover property ($fell(rx_sts_ready_out));
endmodule : host_fifo_port_sva

bind host_fifo_port_access host_fifo_port_sva host_fifo_port_sva_inst (
    .mclk_in(mclk_in), .reset_in(reset_in), .host_addr_in(host_addr_in),
    .host_rd_in(host_rd_in), .host_wr_in(host_wr_in),
    .host_rdata_out(host_rdata_out), .host_rvalid_out(host_rvalid_out),
    .rx_sts_push_in(rx_sts_push_in), .rx_sts_ready_out(rx_sts_ready_out),
    .tx_data_out(tx_data_out), .tx_data_valid_out(tx_data_valid_out),
    .tx_data_pop_in(tx_data_pop_in)
);

/* testbench/host_bus_model.sv */
`timescale 1ns/10ps
module host_bus_model (
    input wire logic mclk_in,
    input wire logic [15:0] host_rdata_in,
    output logic [7:0] host_addr_out,
    output logic host_rd_out,
    output logic host_wr_out,
    output logic [15:0] host_wdata_out
);
    initial begin
        host_addr_out = 8'h00;
        host_rd_out = 1'b0;
        host_wr_out = 1'b0;
        host_wdata_out = 16'h0000;
    end
    // One 16-bit strobe; released lines show inverted values
    task automatic cyc16(input logic [7:0] a, input logic w,
                         input logic [15:0] d, output logic [15:0] q);
        @(negedge mclk_in);
        host_addr_out = a;
        host_wdata_out = d;
        host_rd_out = !w;
        host_wr_out = w;
        @(negedge mclk_in);
        host_rd_out = 1'b0;
        host_wr_out = 1'b0;
        host_addr_out = ~a;
        host_wdata_out = ~d;
        q = host_rdata_in;
    endtask : cyc16
    // Callers pass zeros in reserved bits
    task automatic wr32(input logic [7:0] a, input logic [31:0] d);
        logic [15:0] q;
        if (a >= 8'hA8) begin
            return;
        end
        cyc16({a[7:2], 2'h0}, 1'b1, d[15:0], q);
        cyc16({a[7:2], 2'h2}, 1'b1, d[31:16], q);
    endtask : wr32
    task automatic rd32(input logic [7:0] a, output logic [31:0] d);
        logic [15:0] lo;
        logic [15:0] hi;
        cyc16({a[7:2], 2'h0}, 1'b0, 16'h0000, lo);
        cyc16({a[7:2], 2'h2}, 1'b0, 16'h0000, hi);
        d = {hi, lo};
    endtask : rd32
endmodule : host_bus_model

/* testbench/tb.sv */
`timescale 1ns/10ps
module tb;
    typedef struct packed {
        logic [7:0] addr;
        logic do_wr;
        logic [31:0] wdata;
        logic [31:0] exp;
    } row_t;
    logic mclk_in = 1'b0;
    logic reset_in = 1'b1;
    logic [7:0] host_addr;
    logic host_rd, host_wr, host_rvalid;
    logic [15:0] host_wdata, host_rdata, q16;
    logic [31:0] rx_sts_in = 32'h0, rx_data_in = 32'h0, tx_sts_in = 32'h0;
    logic rx_sts_push_in = 1'b0, rx_data_push_in = 1'b0, tx_sts_push_in = 1'b0;
    logic rx_sts_ready, rx_data_ready, tx_sts_ready, tx_valid;
    logic [31:0] tx_data, v;
    logic tx_data_pop_in = 1'b0, link_in = 1'b1, rx_err_in = 1'b0;
    int error_cnt = 0;
    int cmp_count = 0;
    row_t rows [7] = '{
        '{8'hA4, 1'b1, 32'h1234ABCD, 32'h1234ABCD},
        '{8'h94, 1'b1, 32'h1F1F1F1F, 32'h00000000},
        '{8'hA0, 1'b1, 32'h00000003, 32'h00000000},
        '{8'h40, 1'b0, 32'h00000000, 32'h00000000},
        '{8'h90, 1'b0, 32'h00000000, 32'h00101010},
        '{8'h98, 1'b0, 32'h00000000, 32'h00000000},
        '{8'h9C, 1'b0, 32'h00000000, 32'h00000001}};
    always #2.5 mclk_in = ~mclk_in;
    host_bus_model host_bus_model_inst (.mclk_in(mclk_in),
        .host_rdata_in(host_rdata), .host_addr_out(host_addr),
        .host_rd_out(host_rd), .host_wr_out(host_wr),
        .host_wdata_out(host_wdata));
    host_fifo_port_access host_fifo_port_access_inst (.mclk_in(mclk_in),
        .reset_in(reset_in), .host_addr_in(host_addr), .host_rd_in(host_rd),
        .host_wr_in(host_wr), .host_wdata_in(host_wdata),
        .host_rdata_out(host_rdata), .host_rvalid_out(host_rvalid),
        .rx_sts_in(rx_sts_in), .rx_sts_push_in(rx_sts_push_in),
        .rx_sts_ready_out(rx_sts_ready), .rx_data_in(rx_data_in),
        .rx_data_push_in(rx_data_push_in), .rx_data_ready_out(rx_data_ready),
        .tx_sts_in(tx_sts_in), .tx_sts_push_in(tx_sts_push_in),
        .tx_sts_ready_out(tx_sts_ready), .tx_data_out(tx_data),
        .tx_data_valid_out(tx_valid), .tx_data_pop_in(tx_data_pop_in),
        .link_in(link_in), .rx_err_in(rx_err_in));
    task automatic chk32(input string n, input logic [31:0] e, g);
        cmp_count++;
        if (g !== e) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask : chk32
    task automatic chk1(input string n, input logic e, g);
        cmp_count++;
        if (g !== e) begin
            error_cnt++;
            $display("Error %s expected %b seen %b", n, e, g);
        end
    endtask : chk1
    task automatic rchk(input string n, input logic [7:0] a,
                        input logic [31:0] e);
        logic [31:0] d;
        host_bus_model_inst.rd32(a, d);
        chk32(n, e, d);
    endtask : rchk
    // Far side push or pop pulse, data inverted once released
    task automatic dev_push(input int k, input logic [31:0] d);
        @(negedge mclk_in);
        {rx_sts_in, rx_data_in, tx_sts_in} = {d, d, d};
        rx_sts_push_in = (k == 0);
        rx_data_push_in = (k == 1);
        tx_sts_push_in = (k == 2);
        tx_data_pop_in = (k == 3);
        @(negedge mclk_in);
        {rx_sts_push_in, rx_data_push_in, tx_sts_push_in} = 3'h0;
        tx_data_pop_in = 1'b0;
        {rx_sts_in, rx_data_in, tx_sts_in} = {~d, ~d, ~d};
    endtask : dev_push
    task automatic end_of_test;
        $display("Comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_of_test
    initial begin
        repeat (20000) @(posedge mclk_in);
        error_cnt++;
        end_of_test();
    end
    initial begin
        repeat (10) @(negedge mclk_in);
        reset_in = 1'b0;
        chk1("rx_sts_ready", 1'b1, rx_sts_ready);
        chk1("tx_valid", 1'b0, tx_valid);
        chk1("rx_data_ready", 1'b1, rx_data_ready);
        chk1("tx_sts_ready", 1'b1, tx_sts_ready);
        chk32("rdata", 32'h0, {16'h0, host_rdata});
        foreach (rows[i]) begin
            if (rows[i].do_wr) begin
                host_bus_model_inst.wr32(rows[i].addr, rows[i].wdata);
            end
            rchk("row", rows[i].addr, rows[i].exp);
        end
        dev_push(0, 32'hA1A1A1A1);
        dev_push(0, 32'hB2B2B2B2);
        host_bus_model_inst.wr32(8'h80, 32'h0);
        rchk("rxs_peek", 8'h84, 32'hA1A1A1A1);
        rchk("rxs_peek", 8'h84, 32'hA1A1A1A1);
        host_bus_model_inst.cyc16(8'h80, 1'b0, 16'h0000, q16);
        rchk("rxs_pop", 8'h80, 32'hA1A1A1A1);
        rchk("rxs_pop", 8'h80, 32'hB2B2B2B2);
        dev_push(1, 32'h11111111);
        dev_push(1, 32'h22222222);
        dev_push(1, 32'h33333333);
        host_bus_model_inst.wr32(8'h10, 32'h0);
        rchk("rxd_pop", 8'h00, 32'h11111111);
        rchk("rxd_pop", 8'h3C, 32'h22222222);
        rchk("rxd_pop", 8'h20, 32'h33333333);
        rchk("level", 8'h94, 32'h00000000);
        host_bus_model_inst.rd32(8'h00, v);
        rchk("evt", 8'h98, 32'h00000010);
        host_bus_model_inst.wr32(8'h98, 32'h00000000);
        rchk("evt", 8'h98, 32'h00000010);
        host_bus_model_inst.wr32(8'h98, 32'h00000010);
        rchk("evt", 8'h98, 32'h00000000);
        host_bus_model_inst.wr32(8'h40, 32'hC3C3C3C3);
        host_bus_model_inst.wr32(8'h7C, 32'hD4D4D4D4);
        host_bus_model_inst.cyc16(8'h44, 1'b1, 16'h5555, q16);
        rchk("level", 8'h94, 32'h02000000);
        chk32("tx_data", 32'hC3C3C3C3, tx_data);
        dev_push(3, 32'h0);
        chk32("tx_data", 32'hD4D4D4D4, tx_data);
        dev_push(3, 32'h0);
        chk1("tx_valid", 1'b0, tx_valid);
        host_bus_model_inst.cyc16(8'h42, 1'b1, 16'hBEEF, q16);
        chk32("tx_data", 32'hBEEF0000, tx_data);
        host_bus_model_inst.wr32(8'hA0, 32'h00000002);
        chk1("tx_valid", 1'b0, tx_valid);
        dev_push(2, 32'hE5E5E5E5);
        rchk("txs_peek", 8'h8C, 32'hE5E5E5E5);
        rchk("latch", 8'h9C, 32'h00000101);
        rchk("latch", 8'h9C, 32'h00000001);
        rchk("txs_pop", 8'h88, 32'hE5E5E5E5);
        rchk("level", 8'h94, 32'h00000000);
        @(negedge mclk_in);
        {link_in, rx_err_in} = 2'h1;
        @(negedge mclk_in);
        {link_in, rx_err_in} = 2'h2;
        rchk("latch", 8'h9C, 32'h00000002);
        rchk("latch", 8'h9C, 32'h00000001);
        host_bus_model_inst.wr32(8'h90, 32'h00101008);
        repeat (9) dev_push(0, 32'h0);
        @(negedge mclk_in);
        chk1("rx_sts_ready", 1'b0, rx_sts_ready);
        rchk("level", 8'h94, 32'h00000008);
        rchk("evt", 8'h98, 32'h00000001);
        host_bus_model_inst.wr32(8'h90, 32'h80101008);
        repeat (3) @(negedge mclk_in);
        chk1("rx_sts_ready", 1'b1, rx_sts_ready);
        rchk("evt", 8'h98, 32'h00000000);
        rchk("keep", 8'hA4, 32'h0000ABCD);
        rchk("cfg", 8'h90, 32'h00101010);
        end_of_test();
    end
endmodule : tb
